// >>> rtl/tdl_call_logger.sv
/*
 * Control logic of the tone-dial call logger: line watch, decoder
 * enable, sixty-second timeout, digit capture and call timer.
 * Assumes a synchronous decoder strobe, a one-cycle second tick and
 * that i_rst is the power-on reset.
 */
`timescale 1ns/1ps
module tdl_call_logger #(
    parameter int DEPTH = tdl_pkg::DIGIT_MAX
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Mode switches and line
    input wire logic i_mode_select_switch_a,
    input wire logic i_mode_select_switch_b,
    input wire logic i_line_looped,
    input wire logic i_sec_tick,
    // Tone decoder
    input wire logic i_digit_valid,
    input wire logic [tdl_pkg::DIGIT_W-1:0] i_digit_code,
    // Display read port
    input wire logic [tdl_pkg::ADDR_W-1:0] i_disp_rd_addr,
    output logic [tdl_pkg::DIGIT_W-1:0] o_disp_digit,
    // Power control
    output logic o_decoder_en,
    output logic o_mic_en,
    output logic o_display_on,
    output logic o_powered_down,
    // Record
    output logic [tdl_pkg::COUNT_W-1:0] o_digit_count,
    output logic [tdl_pkg::DIGIT_W-1:0] o_last_digit,
    output logic o_new_digit,
    output logic [7:0] o_hours,
    output logic [7:0] o_minutes,
    output logic [7:0] o_seconds
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tdl_pkg::tdl_state_t state;
    tdl_pkg::tdl_state_t next_state;
    logic acoustic_input_mode;
    logic line_monitor_mode;
    logic [6:0] up_secs;
    logic call_started;
    logic timing;
    logic accept;
    tdl_store_if store ();

    localparam int COUNT_W = tdl_pkg::COUNT_W;

    // Both switches must agree on acoustic input; any split reads as line mode
    assign acoustic_input_mode = i_mode_select_switch_a & i_mode_select_switch_b;
    assign line_monitor_mode = ~acoustic_input_mode;

    always_comb begin
        next_state = state;
        unique case (state)
            tdl_pkg::ST_SLEEP: begin
                if (acoustic_input_mode || i_line_looped) begin
                    next_state = tdl_pkg::ST_LISTEN;
                end
            end
            tdl_pkg::ST_LISTEN: begin
                if (line_monitor_mode && !i_line_looped) begin
                    next_state = tdl_pkg::ST_SLEEP;
                end else if (line_monitor_mode && i_sec_tick && up_secs == tdl_pkg::TIMEOUT_TICKS - 7'h01) begin
                    next_state = tdl_pkg::ST_HOLD;
                end
            end
            tdl_pkg::ST_HOLD: begin
                if (acoustic_input_mode) begin
                    next_state = tdl_pkg::ST_LISTEN;
                end else if (!i_line_looped) begin
                    next_state = tdl_pkg::ST_SLEEP;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= tdl_pkg::ST_SLEEP;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // Seconds since the line looped; restarted on each wake
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            up_secs <= 7'h00;
        end else if (i_ce) begin
            if (state == tdl_pkg::ST_SLEEP) begin
                up_secs <= 7'h00;
            end else if (state == tdl_pkg::ST_LISTEN && i_sec_tick) begin
                up_secs <= up_secs + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Power outputs
    // ------------------------------------------------------------
    assign o_decoder_en = (state == tdl_pkg::ST_LISTEN);
    assign o_mic_en = (state == tdl_pkg::ST_LISTEN);
    assign o_display_on = (state != tdl_pkg::ST_SLEEP);
    assign o_powered_down = (state == tdl_pkg::ST_SLEEP);

    // ------------------------------------------------------------
    // Digit capture
    // ------------------------------------------------------------
    // Only the tone decoder strobe is a digit source; loop pulses never reach here
    assign accept = i_ce && i_digit_valid && o_decoder_en;

    assign store.wr_en = accept && (!call_started || o_digit_count < COUNT_W'(DEPTH));
    assign store.wr_addr = call_started ? o_digit_count[tdl_pkg::ADDR_W-1:0] : '0;
    assign store.wr_data = i_digit_code;
    assign store.rd_addr = i_disp_rd_addr;
    assign o_disp_digit = store.rd_data;

    // Call flag drops on hang-up so the next call's first digit restarts everything
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            call_started <= 1'b0;
        end else if (i_ce) begin
            if (state == tdl_pkg::ST_SLEEP) begin
                call_started <= 1'b0;
            end else if (accept) begin
                call_started <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_digit_count <= tdl_pkg::COUNT_RST;
            o_last_digit <= '0;
            o_new_digit <= 1'b0;
        end else if (i_ce) begin
            o_new_digit <= store.wr_en;
            if (store.wr_en) begin
                o_last_digit <= i_digit_code;
                o_digit_count <= call_started ? o_digit_count + 5'h01 : 5'h01;
            end
        end
    end

    tdl_digit_mem #(
        .DEPTH(DEPTH)
    ) u_mem (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .store(store.mem)
    );

    // ------------------------------------------------------------
    // Call timer
    // ------------------------------------------------------------
    // Runs from the first digit until on-hook; no answer signal exists
    assign timing = call_started && state != tdl_pkg::ST_SLEEP;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last);
        logic [7:0] r;
        r = tdl_pkg::BCD_ZERO;
        if (v != last) begin
            r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_hours <= tdl_pkg::BCD_ZERO;
            o_minutes <= tdl_pkg::BCD_ZERO;
            o_seconds <= tdl_pkg::BCD_ZERO;
        end else if (i_ce) begin
            if (accept && !call_started) begin
                o_hours <= tdl_pkg::BCD_ZERO;
                o_minutes <= tdl_pkg::BCD_ZERO;
                o_seconds <= tdl_pkg::BCD_ZERO;
            end else if (timing && i_sec_tick) begin
                o_seconds <= bcd_inc(o_seconds, tdl_pkg::BCD_SIXTY_LAST);
                if (o_seconds == tdl_pkg::BCD_SIXTY_LAST) begin
                    o_minutes <= bcd_inc(o_minutes, tdl_pkg::BCD_SIXTY_LAST);
                    if (o_minutes == tdl_pkg::BCD_SIXTY_LAST) begin
                        o_hours <= bcd_inc(o_hours, tdl_pkg::BCD_HOURS_LAST);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_wake;
        i_ce && line_monitor_mode && state == tdl_pkg::ST_SLEEP && i_line_looped;
    endsequence
    sequence s_first_digit;
        accept && !call_started;
    endsequence

    AST_WAKE_SHOWS: assert property (s_wake |=> o_display_on && o_decoder_en)
        else $error("Display or decoder not on after looping");
    AST_FIRST_CLEARS:
        assert property (s_first_digit |=> o_digit_count == 5'h01 && o_seconds == 8'h00)
        else $error("First digit did not restart record");
    AST_CAP_16: assert property (o_digit_count <= 5'h10)
        else $error("Digit count above sixteen");
    AST_FULL_HOLD:
        assert property (i_ce && o_digit_count == 5'h10 && call_started |=> o_digit_count == 5'h10)
        else $error("Full store changed");
    AST_TIMEOUT:
        assert property (state == tdl_pkg::ST_LISTEN && line_monitor_mode && i_line_looped && i_ce
        && i_sec_tick && up_secs == tdl_pkg::TIMEOUT_TICKS - 7'h01 |=> !o_decoder_en && !o_mic_en)
        else $error("Decoder still on at timeout");
    AST_HOLD_STAYS:
        assert property (state == tdl_pkg::ST_HOLD && i_line_looped && line_monitor_mode
        |=> !o_mic_en)
        else $error("Microphone re-enabled before on-hook");
    AST_ONHOOK_KEEPS:
        assert property (i_ce && state == tdl_pkg::ST_SLEEP && !i_digit_valid
        |=> $stable(o_digit_count) && $stable(o_seconds))
        else $error("Record changed while on-hook");
    AST_SLEEP_DOWN:
        assert property (i_ce && line_monitor_mode && !i_line_looped |=> o_powered_down)
        else $error("Not powered down on-hook");
    AST_ACOUSTIC_AWAKE:
        assert property (i_ce && acoustic_input_mode ##1 i_ce && acoustic_input_mode
        |=> !o_powered_down)
        else $error("Powered down in acoustic mode");
    AST_SHOW_DIGIT:
        assert property (store.wr_en |=> o_new_digit && o_last_digit == $past(i_digit_code))
        else $error("Digit not shown");
endmodule : tdl_call_logger

// >>> rtl/tdl_pkg.sv
/*
 * Shared constants and types of the tone-dial call logger.
 * Assumes a one-second tick from outside and a power-on reset.
 */
package tdl_pkg;
    // ------------------------------------------------------------
    // Digit store
    // ------------------------------------------------------------
    localparam int DIGIT_W = 4;
    localparam int DIGIT_MAX = 16;
    localparam int ADDR_W = 4;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_RST = 5'h00;
    // ------------------------------------------------------------
    // Timing, counted in one-second ticks
    // ------------------------------------------------------------
    localparam int DECODER_TIMEOUT_S = 60;
    localparam int TICK_S = 1;
    localparam logic [6:0] TIMEOUT_TICKS = 7'(DECODER_TIMEOUT_S / TICK_S);
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_SIXTY_LAST = 8'h59;
    localparam logic [7:0] BCD_HOURS_LAST = 8'h99;
    // ------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_LISTEN,
        ST_HOLD
    } tdl_state_t;
endpackage : tdl_pkg

// >>> rtl/tdl_store_if.sv
/*
 * Write and read port bundle between the logger and its digit memory.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface tdl_store_if;
    logic wr_en;
    logic [tdl_pkg::ADDR_W-1:0] wr_addr;
    logic [tdl_pkg::DIGIT_W-1:0] wr_data;
    logic [tdl_pkg::ADDR_W-1:0] rd_addr;
    logic [tdl_pkg::DIGIT_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : tdl_store_if

// >>> rtl/tdl_digit_mem.sv
/*
 * Small digit memory with registered read data.
 * Assumes the controller tracks how many entries are valid.
 */
`timescale 1ns/1ps
module tdl_digit_mem #(
    parameter int DEPTH = tdl_pkg::DIGIT_MAX
) (
    // Clock and enable
    input wire logic i_clk,
    input wire logic i_ce,
    // Store port
    tdl_store_if.mem store
);
    logic [tdl_pkg::DIGIT_W-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_ce && store.wr_en) begin
            mem[store.wr_addr] <= store.wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            store.rd_data <= mem[store.rd_addr];
        end
    end
endmodule : tdl_digit_mem

// >>> tb/tdl_tone_model.sv
/*
 * Behavioural tone decoder standing at the logger's far side.
 * Assumes the bench asks for one digit at a time, off the clock edge.
 */
`timescale 1ns/1ps
module tdl_tone_model (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_enable,
    input wire logic i_send,
    input wire logic [3:0] i_code,
    // Digit out
    output logic o_valid,
    output logic [3:0] o_code
);
    initial begin
        o_valid = 1'b0;
        o_code = 4'h0;
    end
    // A disabled decoder hears nothing; the code bus garbles between digits
    always @(posedge i_clk) begin
        o_valid <= i_send && i_enable;
        o_code <= (i_send && i_enable) ? i_code : ~o_code;
    end
endmodule : tdl_tone_model

// >>> tb/test_tone_dial_call_logger.sv
/*
 * Self-checking bench of the call logger with a tone decoder model.
 * Assumes ticks may come far faster than once a second.
 */
`timescale 1ns/1ps
module test_tone_dial_call_logger;
    logic i_clk = 1'b0, i_rst = 1'b1, sw_a = 1'b0, sw_b = 1'b0, looped = 1'b0, tick = 1'b0, send = 1'b0;
    logic [3:0] code = 4'h0, rd_addr = 4'h0, disp, last, dcode;
    logic [4:0] count;
    logic [7:0] hh, mm, ss;
    logic dvalid, dec_en, mic_en, disp_on, pdown, new_dig;
    int failures = 0, total_checks = 0, cycles = 0;
    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    always #10 i_clk = ~i_clk;
    tdl_call_logger tdl_call_logger_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_mode_select_switch_a(sw_a), .i_mode_select_switch_b(sw_b), .i_line_looped(looped),
        .i_sec_tick(tick), .i_digit_valid(dvalid), .i_digit_code(dcode), .i_disp_rd_addr(rd_addr),
        .o_disp_digit(disp), .o_decoder_en(dec_en), .o_mic_en(mic_en), .o_display_on(disp_on),
        .o_powered_down(pdown), .o_digit_count(count), .o_last_digit(last), .o_new_digit(new_dig),
        .o_hours(hh), .o_minutes(mm), .o_seconds(ss));
    tdl_tone_model tdl_tone_model_i (.i_clk(i_clk), .i_enable(dec_en), .i_send(send), .i_code(code),
        .o_valid(dvalid), .o_code(dcode));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step
    // Digit reaches the logger one edge after the request, the record one edge later
    task automatic dial(input logic [3:0] c);
        code = c;
        send = 1'b1;
        step();
        send = 1'b0;
        step();
    endtask : dial
    task automatic ticks(input int n);
        repeat (n) begin
            tick = 1'b1;
            step();
            tick = 1'b0;
            step();
        end
    endtask : ticks
    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        rd_addr = a;
        step();
        chk(8'(disp), 8'(exp));
    endtask : rd
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(8'(pdown), 8'h01);
        chk(8'(disp_on), 8'h00);
        chk(8'(count), 8'h00);
        chk({hh[3:0], mm[3:0]}, 8'h00);
        chk(ss, 8'h00);
    endtask : t_reset
    task automatic t_call();
        looped = 1'b1;
        step();
        chk({3'h0, disp_on, dec_en, mic_en, pdown, 1'b0}, 8'h1c);
        ticks(3);
        dial(4'h5);
        chk({new_dig, last, count[2:0]}, 8'ha9);
        chk(ss, 8'h00);
        dial(4'h2);
        dial(4'h8);
        ticks(7);
        chk(ss, 8'h07);
        rd(4'h0, 4'h5);
        rd(4'h2, 4'h8);
        looped = 1'b0;
        step();
        ticks(2);
        chk({7'h0, pdown}, 8'h01);
        chk(ss, 8'h07);
    endtask : t_call
    task automatic t_idle_hangup();
        looped = 1'b1;
        step();
        ticks(2);
        looped = 1'b0;
        step();
        chk({last, 1'b0, count[2:0]}, 8'h83);
        chk(ss, 8'h07);
    endtask : t_idle_hangup
    task automatic t_full();
        looped = 1'b1;
        step();
        dial(4'h0);
        chk(8'(count), 8'h01);
        for (int i = 1; i < 16; i++) begin
            dial(4'(i));
        end
        dial(4'h9);
        chk({new_dig, last, 3'h0}, 8'h78);
        chk(8'(count), 8'h10);
        rd(4'hf, 4'hf);
        looped = 1'b0;
        step();
    endtask : t_full
    task automatic t_timeout();
        looped = 1'b1;
        step();
        dial(4'h4);
        ticks(60);
        step();
        chk({6'h0, dec_en, mic_en}, 8'h00);
        chk({mm[3:0], ss[3:0]}, 8'h10);
        dial(4'h6);
        chk(8'(count), 8'h01);
        ticks(5);
        chk({6'h0, dec_en, mic_en}, 8'h00);
        looped = 1'b0;
        step();
        chk(8'(pdown), 8'h01);
        chk({mm[3:0], ss[3:0]}, 8'h15);
    endtask : t_timeout
    task automatic t_acoustic();
        sw_a = 1'b1;
        sw_b = 1'b1;
        i_rst = 1'b1;
        step();
        i_rst = 1'b0;
        step();
        step();
        chk({pdown, disp_on, count[2:0], 3'h0}, 8'h40);
        dial(4'h9);
        chk({new_dig, last, 3'h0}, 8'hc8);
        ticks(70);
        chk({pdown, dec_en, 6'h0}, 8'h40);
        dial(4'h3);
        chk({last, 1'b0, count[2:0]}, 8'h32);
    endtask : t_acoustic
    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_reset();
        t_call();
        t_idle_hangup();
        t_full();
        t_timeout();
        t_acoustic();
        report_and_stop();
    end
endmodule : test_tone_dial_call_logger
